// >>> common/aad_defs.svh
// register offsets, field positions, reset values for the advertisement block
`ifndef AAD_DEFS_SVH
`define AAD_DEFS_SVH
// word indices (byte address = index * 4)
`define AAD_IDX_CTRL 4'h0
`define AAD_IDX_ADV 4'h4
`define AAD_IDX_LINK 4'h1
`define AAD_IDX_EFF 4'h8
// control register fields
`define AAD_CTRL_SWRST 15
`define AAD_CTRL_PDOWN 11
`define AAD_CTRL_RESTART 9
// advertisement register fields
`define AAD_ADV_ASYM 11
`define AAD_ADV_PAUSE 10
`define AAD_ADV_T4 9
`define AAD_ADV_TXFD 8
`define AAD_ADV_TXHD 7
// reset values and the writable-bit mask
`define AAD_ADV_RST 16'h0D80
`define AAD_CTRL_RST 16'h0000
`define AAD_ADV_RW_MASK 16'h0D80
`define AAD_ADV_FIELD_RST 1'b1
// control bits that clear themselves and are never stored
`define AAD_CTRL_SELFCLR 16'h8200
`endif

// >>> common/aad_pkg.sv
// types shared by the advertisement block
package aad_pkg;
  typedef logic [15:0] aad_word_t;
  typedef logic [3:0] aad_idx_t;
endpackage

// >>> core/aad_adv_regs.sv
// advertisement register bank with deferred effect, Avalon-MM slave
// ==========================================================
`timescale 1ns/100ps
`include "aad_defs.svh"

// ==========================================================
// link pin synchroniser
// ==========================================================
module aad_sync3 (
  input wire logic mclk,
  input wire logic rst,
  input wire logic din,
  output logic dout,
  output logic fell
);
  // three stages; a change counts only once the second and third agree
  logic [2:0] stage_r;
  logic dout_nxt;
  wire [2:0] stage_nxt = {stage_r[1:0], din};
  wire agree = stage_r[1] == stage_r[2];

  assign dout_nxt = agree ? stage_r[2] : dout;
  assign fell = agree & dout & ~stage_r[2];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage_r <= 3'h0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dout <= 1'b0;
    end else begin
      dout <= dout_nxt;
    end
  end
endmodule // aad_sync3

// ==========================================================
// one read-write advertisement bit and its negotiation shadow
// ==========================================================
module aad_adv_field #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic wr_bit,
  input wire logic load,
  output logic stored_r,
  output logic shadow_r
);
  logic stored_nxt;
  logic shadow_nxt;

  assign stored_nxt = wr_en ? wr_bit : stored_r;
  // a trigger in the same cycle as a write picks up the new value
  assign shadow_nxt = load ? stored_nxt : shadow_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stored_r <= RST_VAL;
    end else begin
      stored_r <= stored_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shadow_r <= RST_VAL;
    end else begin
      shadow_r <= shadow_nxt;
    end
  end
endmodule // aad_adv_field

// ==========================================================
// register bank top
// ==========================================================
module aad_adv_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic link_up,
  output aad_pkg::aad_word_t adv_effective,
  output logic soft_reset_pulse,
  output logic an_restart_pulse,
  output logic power_down
);
  import aad_pkg::*;

  // ==========================================================
  // bus decode
  // ==========================================================
  // one wait state: an access is seen on one edge and answered on the next
  logic ack_r;
  wire req = (avs_read | avs_write) & ~ack_r;
  wire aad_idx_t idx = avs_address[5:2];
  wire hit_ctrl = idx == `AAD_IDX_CTRL;
  wire hit_adv = idx == `AAD_IDX_ADV;
  wire hit_link = idx == `AAD_IDX_LINK;
  wire hit_eff = idx == `AAD_IDX_EFF;
  wire mapped = hit_ctrl | hit_adv | hit_link | hit_eff;
  // a write lands only at the edge where waitrequest is seen low
  wire wr = avs_write & ack_r;
  wire rd = req & avs_read;
  wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // ==========================================================
  // control register and trigger events
  // ==========================================================
  aad_word_t ctrl_r;
  wire ctrl_wr = wr & hit_ctrl;
  wire aad_word_t ctrl_wd = (ctrl_r & ~be_mask) | (avs_writedata[15:0] & be_mask);
  wire swrst_ev = ctrl_wr & ctrl_wd[`AAD_CTRL_SWRST];
  wire restart_ev = ctrl_wr & ctrl_wd[`AAD_CTRL_RESTART];
  wire pd_exit_ev = ctrl_wr & ctrl_r[`AAD_CTRL_PDOWN] & ~ctrl_wd[`AAD_CTRL_PDOWN];
  // reset and restart clear themselves, so they are never stored
  wire aad_word_t ctrl_nxt = ctrl_wr ? (ctrl_wd & ~`AAD_CTRL_SELFCLR) : ctrl_r;

  // ==========================================================
  // link state
  // ==========================================================
  logic link_state;
  logic link_fell;

  aad_sync3 u_link_sync (
    .mclk(mclk),
    .rst(rst),
    .din(link_up),
    .dout(link_state),
    .fell(link_fell)
  );

  wire link_drop_ev = link_fell;
  wire trigger = swrst_ev | restart_ev | pd_exit_ev | link_drop_ev;

  // ==========================================================
  // advertisement fields
  // ==========================================================
  logic asym_r;
  logic asym_eff_r;
  logic pause_r;
  logic pause_eff_r;
  logic txfd_r;
  logic txfd_eff_r;
  logic txhd_r;
  logic txhd_eff_r;

  wire adv_wr = wr & hit_adv;
  // bit 9 (100BASE-T4) and the unmodelled bits are tied to zero
  wire aad_word_t adv_val = {4'h0, asym_r, pause_r, 1'b0, txfd_r, txhd_r, 7'h00};
  wire aad_word_t eff_val = {4'h0, asym_eff_r, pause_eff_r, 1'b0, txfd_eff_r, txhd_eff_r, 7'h00};
  wire aad_word_t adv_wd = (adv_val & ~be_mask) | (avs_writedata[15:0] & be_mask);
  wire aad_word_t adv_nxt = adv_wr ? (adv_wd & `AAD_ADV_RW_MASK) : adv_val;
  wire aad_word_t eff_nxt = trigger ? adv_nxt : eff_val;

  aad_adv_field #(
    .RST_VAL(`AAD_ADV_FIELD_RST)
  ) u_asym (
    .mclk(mclk),
    .rst(rst),
    .wr_en(adv_wr),
    .wr_bit(adv_wd[`AAD_ADV_ASYM]),
    .load(trigger),
    .stored_r(asym_r),
    .shadow_r(asym_eff_r)
  );

  aad_adv_field #(
    .RST_VAL(`AAD_ADV_FIELD_RST)
  ) u_pause (
    .mclk(mclk),
    .rst(rst),
    .wr_en(adv_wr),
    .wr_bit(adv_wd[`AAD_ADV_PAUSE]),
    .load(trigger),
    .stored_r(pause_r),
    .shadow_r(pause_eff_r)
  );

  aad_adv_field #(
    .RST_VAL(`AAD_ADV_FIELD_RST)
  ) u_txfd (
    .mclk(mclk),
    .rst(rst),
    .wr_en(adv_wr),
    .wr_bit(adv_wd[`AAD_ADV_TXFD]),
    .load(trigger),
    .stored_r(txfd_r),
    .shadow_r(txfd_eff_r)
  );

  aad_adv_field #(
    .RST_VAL(`AAD_ADV_FIELD_RST)
  ) u_txhd (
    .mclk(mclk),
    .rst(rst),
    .wr_en(adv_wr),
    .wr_bit(adv_wd[`AAD_ADV_TXHD]),
    .load(trigger),
    .stored_r(txhd_r),
    .shadow_r(txhd_eff_r)
  );

  // ==========================================================
  // read mux
  // ==========================================================
  wire [15:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_adv ? adv_val :
                       hit_link ? {13'h0000, link_state, 2'h0} :
                       hit_eff ? eff_val : 16'h0000;

  // ==========================================================
  // sequential state
  // ==========================================================
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `AAD_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================
  // registered outputs
  // ==========================================================
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else begin
      avs_readdata <= rd ? {16'h0000, rd_mux} : 32'h00000000;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~req;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_response <= 2'h0;
    end else begin
      avs_response <= (req & ~mapped) ? 2'h3 : 2'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      adv_effective <= `AAD_ADV_RST;
    end else begin
      adv_effective <= eff_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= swrst_ev;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      an_restart_pulse <= 1'b0;
    end else begin
      an_restart_pulse <= restart_ev;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_down <= 1'b0;
    end else begin
      power_down <= ctrl_nxt[`AAD_CTRL_PDOWN];
    end
  end
endmodule // aad_adv_regs

// >>> sim/aad_adv_regs_assertions.sv
// checker for the advertisement bank ports
`timescale 1ns/100ps
module aad_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic link_up,
  input wire logic [15:0] adv_effective,
  input wire logic soft_reset_pulse,
  input wire logic an_restart_pulse,
  input wire logic power_down
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire wr_ctl = avs_write && !avs_waitrequest && avs_address[5:2] == 4'h0 && avs_byteenable[1];
  wire rd_adv = avs_read && !avs_waitrequest && avs_address[5:2] == 4'h4;
  one_wait_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("ack not one wait state");
  held_adv_a: assert property ($changed(adv_effective) |-> $past(wr_ctl) || !$past(link_up, 2)
    || !$past(link_up, 3) || !$past(link_up, 4)) else $error("shadow moved without trigger");
  swrst_a: assert property (wr_ctl && avs_writedata[15] |=> soft_reset_pulse ##1 !soft_reset_pulse)
    else $error("soft reset pulse wrong");
  restart_a: assert property (wr_ctl && avs_writedata[9] |=> an_restart_pulse ##1 !an_restart_pulse)
    else $error("restart pulse missing");
  pdown_a: assert property (wr_ctl |=> power_down == $past(avs_writedata[11])) else $error("power down bad");
  t4_zero_a: assert property (rd_adv |-> avs_readdata[9] == 1'b0) else $error("t4 bit set");
  adv_ok_a: assert property (rd_adv |-> avs_response == 2'h0) else $error("adv read refused");
  shadow_mask_a: assert property ((adv_effective & ~16'h0D80) == 16'h0) else $error("shadow bad bits");
endmodule // aad_chk
bind aad_adv_regs aad_chk chk (.*);

// >>> sim/aad_adv_regs_tb_top.sv
// register-level testbench for the advertisement bank
`timescale 1ns/100ps
module autoneg_ability_advert_bits_tb_top;
  logic mclk = 0, rst = 1, avs_read = 0, avs_write = 0, link_up = 1;
  logic [5:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, q;
  logic [3:0] avs_byteenable = 4'hF;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, soft_reset_pulse, an_restart_pulse, power_down;
  wire [1:0] avs_response;
  wire [15:0] adv_effective;
  int miscompares = 0, total_checks = 0, cyc = 0;
  aad_adv_regs uut (.*);
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 3000) begin miscompares++; test_done(); end
  task automatic test_done;
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin miscompares++; $display("Error t=%0t seen %h exp %h", $time, s, e); end
  endtask
  // request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] i, input logic [31:0] d);
    avs_write <= w; avs_read <= !w; avs_address <= {i, 2'b00}; avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata; chk(avs_response, (i == 4'h3) ? 2'h3 : 2'h0);
    avs_write <= 0; avs_read <= 0; @(posedge mclk);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 0; @(posedge mclk);
    acc(0, 4, 0); chk(q, 32'h0D80);
    acc(1, 4, 32'hFFFF); acc(0, 4, 0); chk(q, 32'h0D80);
    acc(1, 4, 0); acc(0, 4, 0); chk(q, 0);
    chk(adv_effective, 16'h0D80);
    acc(1, 0, 32'h8000); chk(adv_effective, 0);
    chk(soft_reset_pulse, 1); acc(0, 0, 0); chk(q, 0);
    acc(1, 4, 32'h0880); acc(1, 0, 32'h0200); chk(adv_effective, 16'h0880);
    chk(an_restart_pulse, 1); chk(soft_reset_pulse, 0);
    acc(1, 4, 32'h0500); acc(1, 0, 32'h0800); chk(adv_effective, 16'h0880);
    chk(power_down, 1); acc(0, 0, 0); chk(q, 32'h0800);
    acc(1, 0, 0); chk(adv_effective, 16'h0500);
    acc(1, 8, 32'hFFFF); acc(0, 8, 0); chk(q, 32'h0500);
    acc(0, 1, 0); chk(q, 32'h4);
    acc(1, 4, 32'h0180); link_up <= 0; repeat (8) @(posedge mclk);
    chk(adv_effective, 16'h0180);
    acc(0, 1, 0); chk(q, 0);
    acc(0, 3, 0); chk(q, 0);
    test_done();
  end
endmodule // autoneg_ability_advert_bits_tb_top
